// ### hdl/mswd_top.sv
// Millisecond watchdog with AHB-Lite register slave
// Overview of operation
// [R1] Count decrements once per one-millisecond tick
// [R2] Timeouts span one to 65535 ticks, a full 16-bit field
// [R3] Count advances only in the run power state, else held
// [R4] Software writes timeout with its inverse in the upper half
// [R5] Timeout write with wrong inverse is refused and flagged
// [R6] Every accepted timeout write while enabled restarts the countdown
// [R7] Expiry while enabled pulses the processor tile reset
// [R8] Upper half of control register reads the live count
// [R9] Lower half holds the timeout, reset value one thousand
// [R10] Writing zero to kill switch enables and starts counting
// [R11] Magic value stops and resets the watchdog; reset is magic
// [R12] Expiry also pulses the system reset request
// [R13] Tick derives from oscillator using programmed MHz setting
// [R14] Other kill switch values leave enable state unchanged
`timescale 1ns/1ps
module mswd_top (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Chip power state and reset requests
  input  wire logic        runPowerState,
  output logic             tileResetPulse,
  output logic             systemResetPulse
);
  // ==========================================================
  // Declarations
  mswd_pkg::mswd_state_t stateReg, stateNext;
  logic [15:0] timeoutReg, timeoutNext;
  logic [15:0] countReg, countNext;
  logic [31:0] killReg, killNext;
  logic [6:0]  freqReg, freqNext;
  logic        nackReg, nackNext;
  logic        tileReg, tileNext;
  logic        sysReg, sysNext;
  logic        wrPendReg, wrPendNext;
  logic        rdPendReg, rdPendNext;
  logic [7:0]  idxReg, idxNext;
  logic [31:0] rdataReg, rdataNext;
  logic        readyReg, readyNext;
  logic        take;
  logic        wTimeout;
  logic        wKill;
  logic        wFreq;
  logic        toValid;
  logic        tickRun;
  logic        expire;

  mswd_tick_if tickIf ();

  mswd_tick_gen u_tick (
    .clk    (clk),
    .rst    (rst),
    .tickIf (tickIf.gen)
  );

  assign tickIf.freqMhz = freqReg;

  // ==========================================================
  // Bus address and data phase tracking
  assign take = hsel & htrans[1] & hready;

  always_comb begin
    wrPendNext = take & hwrite;
    rdPendNext = take & ~hwrite;
    idxNext    = idxReg;
    readyNext  = 1'b1;
    rdataNext  = rdataReg;
    if (take) begin
      if (haddr[31:mswd_pkg::ADDR_HI_LSB] == '0) begin
        idxNext = haddr[mswd_pkg::IDX_MSB:mswd_pkg::IDX_LSB];
      end else begin
        idxNext = mswd_pkg::IDX_NONE;
      end
      readyNext = hwrite;
    end
    if (rdPendReg) begin
      case (idxReg)
        mswd_pkg::IDX_TIMEOUT: rdataNext = {countReg, timeoutReg}; // R8
        mswd_pkg::IDX_KILL:    rdataNext = killReg;
        mswd_pkg::IDX_FREQ:    rdataNext = 32'(freqReg);
        mswd_pkg::IDX_STATUS: begin
          rdataNext = '0;
          rdataNext[mswd_pkg::ST_NACK] = nackReg;
          rdataNext[mswd_pkg::ST_EN] = (stateReg != mswd_pkg::WD_OFF);
        end
        default: rdataNext = '0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPendReg <= 1'b0;
      rdPendReg <= 1'b0;
      idxReg    <= mswd_pkg::IDX_NONE;
      readyReg  <= 1'b1;
      rdataReg  <= '0;
    end else begin
      wrPendReg <= wrPendNext;
      rdPendReg <= rdPendNext;
      idxReg    <= idxNext;
      readyReg  <= readyNext;
      rdataReg  <= rdataNext;
    end
  end

  assign hrdata    = rdataReg;
  assign hreadyout = readyReg;
  assign hresp     = 1'b0;

  // ==========================================================
  // Write decode, data phase
  assign wTimeout = wrPendReg & (idxReg == mswd_pkg::IDX_TIMEOUT);
  assign wKill    = wrPendReg & (idxReg == mswd_pkg::IDX_KILL);
  assign wFreq    = wrPendReg & (idxReg == mswd_pkg::IDX_FREQ);
  assign toValid  = (hwdata[mswd_pkg::CNT_MSB:mswd_pkg::CNT_LSB]
                     == ~hwdata[mswd_pkg::TO_MSB:0]); // R5
  assign tickRun  = tickIf.tick & runPowerState; // R3
  assign expire   = (stateReg == mswd_pkg::WD_RUN) & tickRun
                    & (countReg <= mswd_pkg::COUNT_LAST);

  // ==========================================================
  // Watchdog state and counter
  always_comb begin
    stateNext   = stateReg;
    timeoutNext = timeoutReg;
    countNext   = countReg;
    killNext    = killReg;
    freqNext    = freqReg;
    nackNext    = nackReg;
    tileNext    = 1'b0;
    sysNext     = 1'b0;
    case (stateReg)
      mswd_pkg::WD_OFF: begin
        countNext = mswd_pkg::COUNT_RST; // R11
      end
      mswd_pkg::WD_RUN: begin
        if (expire) begin
          stateNext = mswd_pkg::WD_FIRE;
          countNext = timeoutReg;
          tileNext  = 1'b1; // R7
          sysNext   = 1'b1; // R12
        end else if (tickRun) begin
          countNext = 16'(countReg - 16'h0001); // R1
        end
      end
      mswd_pkg::WD_FIRE: begin
        stateNext = mswd_pkg::WD_RUN;
      end
      default: begin
        stateNext = mswd_pkg::WD_OFF;
      end
    endcase
    if (wTimeout) begin
      if (toValid) begin
        timeoutNext = hwdata[mswd_pkg::TO_MSB:0]; // R2 R9
        if (stateReg != mswd_pkg::WD_OFF) begin
          countNext = hwdata[mswd_pkg::TO_MSB:0]; // R6
        end
        nackNext    = 1'b0;
      end else begin
        nackNext    = 1'b1; // R5
      end
    end
    if (wKill) begin
      killNext = hwdata;
      nackNext = 1'b0;
      if (hwdata == mswd_pkg::KILL_MAGIC) begin
        stateNext = mswd_pkg::WD_OFF; // R11
        countNext = mswd_pkg::COUNT_RST;
      end else if (hwdata == mswd_pkg::KILL_ENABLE
                   && stateReg == mswd_pkg::WD_OFF) begin // R14
        stateNext = mswd_pkg::WD_RUN; // R10
        countNext = timeoutReg;
      end
    end
    if (wFreq) begin
      if (hwdata >= 32'(mswd_pkg::FREQ_MIN)
          && hwdata <= 32'(mswd_pkg::FREQ_MAX)) begin
        freqNext = hwdata[6:0]; // R13
        nackNext = 1'b0;
      end else begin
        nackNext = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stateReg   <= mswd_pkg::WD_OFF;
      timeoutReg <= mswd_pkg::TIMEOUT_RST; // R9
      countReg   <= mswd_pkg::COUNT_RST;
      killReg    <= mswd_pkg::KILL_MAGIC; // R11
      freqReg    <= mswd_pkg::FREQ_RST;
      nackReg    <= 1'b0;
      tileReg    <= 1'b0;
      sysReg     <= 1'b0;
    end else begin
      stateReg   <= stateNext;
      timeoutReg <= timeoutNext;
      countReg   <= countNext;
      killReg    <= killNext;
      freqReg    <= freqNext;
      nackReg    <= nackNext;
      tileReg    <= tileNext;
      sysReg     <= sysNext;
    end
  end

  assign tileResetPulse   = tileReg;
  assign systemResetPulse = sysReg;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence sBadTimeout;
    wTimeout && !toValid;
  endsequence

  sequence sGoodTimeout;
    wTimeout && toValid && !wKill && stateReg != mswd_pkg::WD_OFF;
  endsequence

  sequence sKillMagic;
    wKill && hwdata == mswd_pkg::KILL_MAGIC;
  endsequence

  sequence sFirePulse;
    tileResetPulse && systemResetPulse ##1
    !tileResetPulse && !systemResetPulse;
  endsequence

  a_nack_bad_write: assert property ( // R5
    sBadTimeout |=> nackReg && $stable(timeoutReg))
    else $error("bad timeout write not refused");

  a_kick_reload: assert property ( // R6
    sGoodTimeout |=> countReg == $past(hwdata[15:0])
                     && timeoutReg == $past(hwdata[15:0]))
    else $error("accepted write did not reload count");

  a_tick_decrement: assert property ( // R1
    stateReg == mswd_pkg::WD_RUN && tickRun && !expire && !wrPendReg
    |=> countReg == 16'($past(countReg) - 16'h0001))
    else $error("count did not step on tick");

  a_hold_asleep: assert property ( // R3
    !runPowerState && !wrPendReg && stateReg != mswd_pkg::WD_FIRE
    |=> $stable(countReg))
    else $error("count moved outside run power state");

  a_expiry_reset: assert property ( // R7
    expire && !wrPendReg |=> sFirePulse)
    else $error("expiry did not pulse resets once");

  a_no_spurious_rst: assert property ( // R7
    tileResetPulse |-> $past(expire))
    else $error("reset pulse without expiry");

  a_kill_stops: assert property ( // R11
    sKillMagic |=> stateReg == mswd_pkg::WD_OFF
                   ##1 stateReg == mswd_pkg::WD_OFF || $past(wrPendReg))
    else $error("magic write did not stop watchdog");

  a_enable_runs: assert property ( // R10
    stateReg == mswd_pkg::WD_OFF && wKill
    && hwdata == mswd_pkg::KILL_ENABLE |=> stateReg == mswd_pkg::WD_RUN)
    else $error("zero write did not enable watchdog");

  a_other_kept: assert property ( // R14
    wKill && hwdata != mswd_pkg::KILL_ENABLE
    && hwdata != mswd_pkg::KILL_MAGIC && stateReg == mswd_pkg::WD_OFF
    |=> stateReg == mswd_pkg::WD_OFF)
    else $error("other kill value changed enable state");

  a_count_field: assert property ( // R8
    rdPendReg && idxReg == mswd_pkg::IDX_TIMEOUT
    |=> hreadyout && hrdata[31:16] == $past(countReg))
    else $error("read of live count wrong");

  a_off_count_zero: assert property ( // R11
    stateReg == mswd_pkg::WD_OFF && !wKill
    |=> countReg == mswd_pkg::COUNT_RST)
    else $error("disabled watchdog count not cleared");

  a_freq_refused: assert property ( // R13
    wFreq && (hwdata < 32'(mswd_pkg::FREQ_MIN)
              || hwdata > 32'(mswd_pkg::FREQ_MAX))
    |=> nackReg && $stable(freqReg))
    else $error("out of range frequency not refused");
endmodule // mswd_top

// ### common/mswd_pkg.sv
// Constants and types shared by the millisecond watchdog design
package mswd_pkg;
  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [7:0]  IDX_TIMEOUT   = 8'hD6;
  localparam logic [7:0]  IDX_KILL      = 8'hD7;
  localparam logic [7:0]  IDX_FREQ      = 8'hD8;
  localparam logic [7:0]  IDX_STATUS    = 8'hD9;
  localparam logic [7:0]  IDX_NONE      = 8'hFF;
  localparam int          IDX_LSB       = 2;
  localparam int          IDX_MSB       = 9;
  localparam int          ADDR_HI_LSB   = 10;
  // ==========================================================
  // Field layout and reset values
  localparam int          CNT_LSB       = 16;
  localparam int          CNT_MSB       = 31;
  localparam int          TO_MSB        = 15;
  localparam logic [15:0] TIMEOUT_RST   = 16'h03E8;
  localparam logic [15:0] COUNT_LAST    = 16'h0001;
  localparam logic [15:0] COUNT_RST     = 16'h0000;
  localparam logic [31:0] KILL_MAGIC    = 32'h0D15_AB1E;
  localparam logic [31:0] KILL_ENABLE   = 32'h0000_0000;
  localparam logic [6:0]  FREQ_RST      = 7'h19;
  localparam logic [6:0]  FREQ_MIN      = 7'h05;
  localparam logic [6:0]  FREQ_MAX      = 7'h64;
  localparam int          ST_NACK       = 0;
  localparam int          ST_EN         = 1;
  // ==========================================================
  // Tick timing: one tick per millisecond
  localparam int          TICK_MS       = 1;
  localparam int          US_PER_MS     = 1000;
  localparam logic [9:0]  US_PER_TICK   = 10'(TICK_MS * US_PER_MS);
  // ==========================================================
  // Watchdog states, Gray along off -> run -> fire
  typedef enum logic [1:0] {
    WD_OFF  = 2'b00,
    WD_RUN  = 2'b01,
    WD_FIRE = 2'b11
  } mswd_state_t;
endpackage

// ### common/mswd_tick_if.sv
// Tick carrier between the watchdog core and its tick divider
`timescale 1ns/1ps
interface mswd_tick_if;
  logic [6:0] freqMhz;
  logic       tick;
  modport gen  (input freqMhz, output tick);
  modport user (output freqMhz, input tick);
endinterface

// ### hdl/mswd_tick_gen.sv
// Divider making the one-millisecond tick from the oscillator
`timescale 1ns/1ps
module mswd_tick_gen (
  // Clock and reset
  input wire logic   clk,
  input wire logic   rst,
  // Tick carrier
  mswd_tick_if.gen   tickIf
);
  logic [6:0] usCntReg, usCntNext;
  logic [9:0] msCntReg, msCntNext;
  logic       tickReg, tickNext;
  logic       usWrap;

  // ==========================================================
  // Microsecond then millisecond division
  always_comb begin
    usWrap    = (usCntReg >= 7'(tickIf.freqMhz - 7'h01)); // R13
    usCntNext = usWrap ? 7'h00 : 7'(usCntReg + 7'h01);
    msCntNext = msCntReg;
    tickNext  = 1'b0;
    if (usWrap) begin
      if (msCntReg >= 10'(mswd_pkg::US_PER_TICK - 10'h001)) begin
        msCntNext = 10'h000;
        tickNext  = 1'b1; // R13
      end else begin
        msCntNext = 10'(msCntReg + 10'h001);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      usCntReg <= 7'h00;
      msCntReg <= 10'h000;
      tickReg  <= 1'b0;
    end else begin
      usCntReg <= usCntNext;
      msCntReg <= msCntNext;
      tickReg  <= tickNext;
    end
  end

  assign tickIf.tick = tickReg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_tick_spacing: assert property (tickReg |=> !tickReg [*8]) // R13
    else $error("watchdog ticks too close together");
endmodule // mswd_tick_gen

// ### dv/test_millisecond_watchdog.sv
// Self-checking bench for the millisecond watchdog
`timescale 1ns/1ps
module test_millisecond_watchdog;
  // ==========================================================
  // Stimulus and observed signals
  logic        clk           = 1'b0;
  logic        rst           = 1'b1;
  logic        hsel          = 1'b0;
  logic [31:0] haddr         = 32'h0000_0000;
  logic [1:0]  htrans        = 2'b00;
  logic        hwrite        = 1'b0;
  logic [2:0]  hsize         = 3'b010;
  logic [31:0] hwdata        = 32'h0000_0000;
  logic        runPowerState = 1'b1;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        tileResetPulse;
  logic        systemResetPulse;
  logic [31:0] seed          = 32'h0001_0E86;
  int          bad_count     = 0;
  int          num_checks    = 0;
  int          cyc           = 0;
  int          pulses        = 0;
  int          lastPulse     = 0;

  mswd_top dut (
    .clk              (clk),
    .rst              (rst),
    .hsel             (hsel),
    .haddr            (haddr),
    .htrans           (htrans),
    .hwrite           (hwrite),
    .hsize            (hsize),
    .hwdata           (hwdata),
    .hready           (hreadyout),
    .hrdata           (hrdata),
    .hreadyout        (hreadyout),
    .hresp            (hresp),
    .runPowerState    (runPowerState),
    .tileResetPulse   (tileResetPulse),
    .systemResetPulse (systemResetPulse)
  );

  initial begin
    forever #5 clk = ~clk;
  end

  // ==========================================================
  // Checking and bus helpers
  task automatic complete_run();
    if (bad_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [31:0] toWord(input logic [15:0] n);
    return {~n, n};
  endfunction

  function automatic int period(input int n, input int f);
    return n * f * 1000;
  endfunction

  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {22'h00_0000, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] t;
    bus(1'b1, idx, d, t);
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] t;
    bus(1'b0, idx, 32'h0000_0000, t);
    chk(t, exp);
  endtask

  task automatic waitPulse(input int lim);
    int p;
    int i;
    p = pulses;
    for (i = 0; i < lim && pulses == p; i++) @(posedge clk);
    chk(32'(pulses != p), 32'h0000_0001);
  endtask

  // ==========================================================
  // Reset pulse monitor
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (tileResetPulse === 1'b1) begin
      pulses    <= pulses + 1;
      lastPulse <= cyc;
    end
    chk({31'h0, systemResetPulse}, {31'h0, tileResetPulse});
    chk({31'h0, hresp}, 32'h0000_0000);
  end

  initial begin
    #1_000_000;
    bad_count++;
    complete_run();
  end

  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] t;
    logic [15:0] n;
    int          p0;
    int          t0;
    int          i;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdchk(mswd_pkg::IDX_TIMEOUT, 32'h0000_03E8);
    rdchk(mswd_pkg::IDX_KILL, 32'h0D15_AB1E);
    rdchk(mswd_pkg::IDX_STATUS, 32'h0000_0000);
    rdchk(mswd_pkg::IDX_NONE, 32'h0000_0000);
    wr(mswd_pkg::IDX_FREQ, 32'h0000_0065);
    rdchk(mswd_pkg::IDX_STATUS, 32'h0000_0001);
    wr(mswd_pkg::IDX_FREQ, 32'h0000_0005);
    rdchk(mswd_pkg::IDX_FREQ, 32'h0000_0005);
    t = rnd();
    wr(mswd_pkg::IDX_TIMEOUT,
       {~t[15:0] ^ (16'h0001 << t[19:16]), t[15:0]});
    rdchk(mswd_pkg::IDX_STATUS, 32'h0000_0001);
    rdchk(mswd_pkg::IDX_TIMEOUT, 32'h0000_03E8);
    wr(mswd_pkg::IDX_TIMEOUT, toWord(16'hFFFF));
    rdchk(mswd_pkg::IDX_TIMEOUT, 32'h0000_FFFF);
    rdchk(mswd_pkg::IDX_STATUS, 32'h0000_0000);
    n = 16'h0002 + 16'(rnd() % 2);
    wr(mswd_pkg::IDX_TIMEOUT, toWord(n));
    p0 = pulses;
    repeat (6000) @(posedge clk);
    chk(pulses, p0);
    rdchk(mswd_pkg::IDX_TIMEOUT, {16'h0000, n});
    // Expiry period with the fastest tick
    wr(mswd_pkg::IDX_KILL, 32'h0000_0000);
    rdchk(mswd_pkg::IDX_STATUS, 32'h0000_0002);
    waitPulse(period(n, 5) + 6000);
    t0 = lastPulse;
    waitPulse(period(n, 5) + 100);
    chk(lastPulse - t0, period(n, 5));
    // Count frozen outside the run power state
    runPowerState <= 1'b0;
    bus(1'b0, mswd_pkg::IDX_TIMEOUT, 32'h0000_0000, t);
    p0 = pulses;
    repeat (8000) @(posedge clk);
    rdchk(mswd_pkg::IDX_TIMEOUT, t);
    chk(pulses, p0);
    runPowerState <= 1'b1;
    // Regular kicks keep the tile out of reset
    wr(mswd_pkg::IDX_TIMEOUT, toWord(16'h0003));
    p0 = pulses;
    for (i = 0; i < 3; i++) begin
      repeat (8000) @(posedge clk);
      wr(mswd_pkg::IDX_TIMEOUT, toWord(16'h0003));
    end
    chk(pulses, p0);
    t = (rnd() | 32'h0000_0100) & 32'hFFFF_FDFF;
    wr(mswd_pkg::IDX_KILL, t);
    rdchk(mswd_pkg::IDX_KILL, t);
    rdchk(mswd_pkg::IDX_STATUS, 32'h0000_0002);
    wr(mswd_pkg::IDX_KILL, 32'h0D15_AB1E);
    rdchk(mswd_pkg::IDX_STATUS, 32'h0000_0000);
    rdchk(mswd_pkg::IDX_TIMEOUT, 32'h0000_0003);
    wr(mswd_pkg::IDX_KILL, t);
    rdchk(mswd_pkg::IDX_STATUS, 32'h0000_0000);
    p0 = pulses;
    repeat (12000) @(posedge clk);
    chk(pulses, p0);
    complete_run();
  end
endmodule // test_millisecond_watchdog
